// ### logic/epm_consts.svh
// Constants for the encoder plausibility monitor
`ifndef EPM_CONSTS_SVH
`define EPM_CONSTS_SVH
`define EPM_CONFIRM_COUNT 10
`define EPM_MIN_SPEED_RPM 48
`define EPM_EMF_PERCENT 10
`define EPM_EMF_SCALE 16'h2292
`define EPM_CAUSE_NONE 2'h0
`define EPM_CAUSE_CABLE 2'h1
`define EPM_CAUSE_ENCODER 2'h2
`endif

// ### logic/epm_counter.sv
// Consecutive-evaluation counter with saturation
`timescale 1ns/1ps
`default_nettype none
module epm_counter #(
  parameter int unsigned LIMIT = 10
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset
  input wire logic step, // Evaluation strobe
  input wire logic bad, // Evaluation counted as bad
  output logic hit // Limit reached
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_r;
  logic hit_r;
  // Count bad evaluations, restart on any good one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (step) begin
      if (!bad) begin
        cnt_r <= '0;
      end else if (cnt_r != W'(LIMIT)) begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end
  // Confirmation strobe, one cycle after each confirming evaluation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= step && bad && (cnt_r >= W'(LIMIT - 1));
    end
  end
  // A pulse, so an acknowledge wins once the bad evaluations stop
  assign hit = hit_r;

  chk_cnt_restart: assert property (@(posedge clk) disable iff (rst)
    (step && !bad) |=> (cnt_r == '0 && !hit_r))
    else $error("count not restarted by a good evaluation");
endmodule
`default_nettype wire

// ### logic/epm_monitor.sv
// Encoder plausibility monitor top
// Behaviour
// - Ten consecutive reversals at >=48 rev/min and EMF above threshold give cause 1
// - Ten consecutive implausible evaluations with EMF above threshold give cause 2
// - Implausible means reversals, close edges, lost line or shorted lines
// - Both causes suppressed until EMF exceeds 10% of rated voltage*3*sqrt2/pi
// - Cause code 1 means disturbed cabling, code 2 defective encoder
// - Monitoring stays active in every converter operating state
// - A spurious level change on a line counts as a direction reversal
// - Active cause stays readable in fault value readout after acknowledge
`include "epm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module epm_monitor
  import epm_pkg::*;
#(
  parameter int unsigned CONFIRM = `EPM_CONFIRM_COUNT,
  parameter int unsigned VW = 16
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic eval_valid, // One evaluation done
  input wire epm_eval_t eval, // Evaluation result
  input wire logic [15:0] speed_rpm, // Absolute speed
  input wire logic [VW-1:0] emf, // Measured EMF
  input wire logic [VW-1:0] rated_supply_voltage_setting, // Rated supply
  input wire logic fault_ack, // Acknowledge pulse
  output logic encoder_channel_fault, // Fault active
  output logic [1:0] fault_value_readout // Cause code
);
  // Threshold: V*10%*3*sqrt2/pi ~= V*0.135047; scaled by 2^16 = 8850
  localparam logic [15:0] EMF_K = `EPM_EMF_SCALE;
  logic [VW+15:0] thr_prod;
  logic emf_ok, speed_ok, implaus;
  logic bad_cable, bad_enc;
  logic [3:0] cab_run_r;
  logic [3:0] enc_run_r;
  logic hit_cable, hit_enc;
  logic fault_r;
  logic [1:0] cause_r;
  assign thr_prod = rated_supply_voltage_setting * EMF_K;
  // EMF gate, no operating-state qualifier
  assign emf_ok = ({emf, 16'h0000} > thr_prod);
  assign speed_ok = (speed_rpm >= 16'(`EPM_MIN_SPEED_RPM));
  // Spurious edges arrive as eval.reversal from the evaluator
  assign implaus = eval.reversal | eval.close_edges | eval.line_lost
    | eval.lines_shorted;
  // Per-evaluation verdicts for the two causes
  assign bad_cable = eval.reversal & speed_ok & emf_ok;
  assign bad_enc = implaus & emf_ok;
  // Cabling counter, gated by speed and EMF
  epm_counter #(.LIMIT(CONFIRM)) u_cable (
    .clk(clk),
    .rst(rst),
    .step(eval_valid),
    .bad(bad_cable),
    .hit(hit_cable)
  );
  // Encoder counter, EMF gate only
  epm_counter #(.LIMIT(CONFIRM)) u_enc (
    .clk(clk),
    .rst(rst),
    .step(eval_valid),
    .bad(bad_enc),
    .hit(hit_enc)
  );
  // Fault flag: set wins over acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (hit_cable | hit_enc) begin
      fault_r <= 1'b1;
    end else if (fault_ack) begin
      fault_r <= 1'b0;
    end
  end
  // Cause code latched on new fault, kept after acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_r <= `EPM_CAUSE_NONE;
    end else if (!fault_r && hit_cable) begin
      cause_r <= `EPM_CAUSE_CABLE;
    end else if (!fault_r && hit_enc) begin
      cause_r <= `EPM_CAUSE_ENCODER;
    end
  end
  assign encoder_channel_fault = fault_r;
  assign fault_value_readout = cause_r;

  // Shadow run length of cabling evaluations, read by checks only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cab_run_r <= 4'h0;
    end else if (eval_valid) begin
      if (!bad_cable) begin
        cab_run_r <= 4'h0;
      end else if (cab_run_r != 4'hF) begin
        cab_run_r <= cab_run_r + 4'h1;
      end
    end
  end

  // Shadow run length of implausible evaluations, read by checks only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enc_run_r <= 4'h0;
    end else if (eval_valid) begin
      if (!bad_enc) begin
        enc_run_r <= 4'h0;
      end else if (enc_run_r != 4'hF) begin
        enc_run_r <= enc_run_r + 4'h1;
      end
    end
  end

  // Confirming evaluation of each cause
  sequence s_cable_tenth;
    eval_valid && bad_cable && (cab_run_r == 4'(CONFIRM - 1));
  endsequence
  sequence s_enc_tenth;
    eval_valid && bad_enc && (enc_run_r == 4'(CONFIRM - 1));
  endsequence
  // No confirmation pending this cycle
  sequence s_quiet;
    !hit_cable && !hit_enc;
  endsequence
  // Acknowledge while a fault stands
  sequence s_ack_held;
    fault_r && fault_ack;
  endsequence

  chk_cable_cause: assert property (@(posedge clk) disable iff (rst)
    (!fault_r && hit_cable) |=> (fault_r && cause_r == 2'h1))
    else $error("cable cause not reported");
  chk_enc_cause: assert property (@(posedge clk) disable iff (rst)
    (!fault_r && !hit_cable && hit_enc) |=> (cause_r == 2'h2))
    else $error("encoder cause not reported");
  chk_low_emf: assert property (@(posedge clk) disable iff (rst)
    (!fault_r && !emf_ok) |=> !$rose(fault_r))
    else $error("fault raised below threshold");
  chk_cause_hold: assert property (@(posedge clk) disable iff (rst)
    $fell(fault_r) |-> $stable(cause_r))
    else $error("cause lost at acknowledge");

  chk_cable_confirm: assert property (@(posedge clk) disable iff (rst)
    s_cable_tenth |=> hit_cable ##1 fault_r)
    else $error("cabling fault not raised after confirmation");

  chk_enc_confirm: assert property (@(posedge clk) disable iff (rst)
    s_enc_tenth |=> hit_enc ##1 fault_r)
    else $error("encoder fault not raised after confirmation");

  chk_cable_early: assert property (@(posedge clk) disable iff (rst)
    hit_cable |-> (cab_run_r >= 4'(CONFIRM)))
    else $error("cabling cause confirmed too early");

  chk_enc_early: assert property (@(posedge clk) disable iff (rst)
    hit_enc |-> (enc_run_r >= 4'(CONFIRM)))
    else $error("encoder cause confirmed too early");

  chk_set_wins: assert property (@(posedge clk) disable iff (rst)
    (hit_cable || hit_enc) |=> fault_r)
    else $error("confirmation lost against acknowledge");

  chk_ack_clear: assert property (@(posedge clk) disable iff (rst)
    s_ack_held ##0 s_quiet |=> !fault_r)
    else $error("acknowledge did not clear the fault");

  chk_ack_keeps: assert property (@(posedge clk) disable iff (rst)
    s_ack_held |=> $stable(cause_r))
    else $error("cause changed at acknowledge");

  chk_speed_gate: assert property (@(posedge clk) disable iff (rst)
    (eval_valid && !speed_ok) |=> (cab_run_r == 4'h0 && !hit_cable))
    else $error("cabling count kept below minimum speed");

  chk_emf_gate: assert property (@(posedge clk) disable iff (rst)
    (eval_valid && !emf_ok) |=> (!hit_cable && !hit_enc))
    else $error("confirmation below the EMF threshold");

  chk_cause_code: assert property (@(posedge clk) disable iff (rst)
    fault_r |-> (cause_r == `EPM_CAUSE_CABLE
      || cause_r == `EPM_CAUSE_ENCODER))
    else $error("fault standing without a cause code");

  chk_fault_source: assert property (@(posedge clk) disable iff (rst)
    $rose(fault_r) |-> $past(hit_cable || hit_enc))
    else $error("fault raised without a confirmation");

  chk_idle_hold: assert property (@(posedge clk) disable iff (rst)
    (!fault_r) ##0 s_quiet |=> !fault_r)
    else $error("fault raised while nothing was confirmed");

  chk_reversal_path: assert property (@(posedge clk) disable iff (rst)
    (eval_valid && eval.reversal && emf_ok) |=> (enc_run_r != 4'h0))
    else $error("reversal not counted as implausible");

  chk_good_restart: assert property (@(posedge clk) disable iff (rst)
    (eval_valid && !implaus) |=> (enc_run_r == 4'h0 && !hit_enc))
    else $error("encoder count kept after a good evaluation");
endmodule
`default_nettype wire

// ### logic/epm_pkg.sv
// Types for the encoder plausibility monitor
package epm_pkg;
  // One encoder evaluation result
  typedef struct packed {
    logic reversal;
    logic close_edges;
    logic line_lost;
    logic lines_shorted;
  } epm_eval_t;
  typedef enum logic [1:0] {
    EPM_CAUSE_NONE_E,
    EPM_CAUSE_CABLE_E,
    EPM_CAUSE_ENCODER_E
  } epm_cause_t;
endpackage

// ### tb/epm_enc_model.sv
// Behavioural encoder side producing evaluation strobes
`timescale 1ns/1ps
`default_nettype none
module epm_enc_model
  import epm_pkg::*;
(
  input wire logic clk, // Bench clock
  output logic eval_valid, // Evaluation strobe
  output epm_eval_t eval // Evaluation result
);
  initial eval_valid = 1'b0;
  initial eval = 4'h0;
  // Emit n results, then release with the inverse pattern
  task automatic burst(input epm_eval_t p, input int n);
    repeat (n) begin
      @(negedge clk);
      eval_valid = 1'b1;
      eval = p;
    end
    @(negedge clk);
    eval_valid = 1'b0;
    eval = ~p;
  endtask
endmodule
`default_nettype wire

// ### tb/epm_monitor_tb.sv
// Bench for the encoder plausibility monitor
`timescale 1ns/1ps
`default_nettype none
module epm_monitor_tb;
  import epm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ev, ack = 1'b0, flt;
  logic [15:0] spd = 16'h0064, emf = 16'h00C8;
  logic [1:0] cause;
  epm_eval_t e;
  int errors = 0, checked = 0, cyc = 0;
  // Clock and hang guard
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  epm_enc_model enc_u (.clk(clk), .eval_valid(ev), .eval(e));
  epm_monitor dut_u (.clk(clk), .rst(rst), .eval_valid(ev), .eval(e),
    .speed_rpm(spd), .emf(emf), .rated_supply_voltage_setting(16'h03E8),
    .fault_ack(ack), .encoder_channel_fault(flt), .fault_value_readout(cause));
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Reset, send n results, judge flag and cause two edges on
  task automatic run(input epm_eval_t p, input int n, input logic [2:0] x);
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    enc_u.burst(p, n);
    repeat (2) @(negedge clk);
    chk({flt, cause}, x);
  endtask
  task automatic t_cable();
    run(4'h8, 10, 3'h5);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    @(negedge clk);
    chk({flt, cause}, 3'h1);
  endtask
  task automatic t_speed();
    spd = 16'h002F;
    run(4'h8, 10, 3'h6);
    spd = 16'h0030;
    run(4'h8, 10, 3'h5);
  endtask
  task automatic t_kinds();
    for (int i = 0; i < 3; i++) run(4'h1 << i, 10, 3'h6);
  endtask
  task automatic t_emf();
    emf = 16'h0087;
    run(4'h2, 10, 3'h0);
    emf = 16'h0088;
    run(4'h2, 10, 3'h6);
  endtask
  task automatic t_restart();
    run(4'h4, 9, 3'h0);
    enc_u.burst(4'h0, 1);
    enc_u.burst(4'h4, 9);
    repeat (2) @(negedge clk);
    chk({flt, cause}, 3'h0);
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_cable();
    t_speed();
    t_kinds();
    t_emf();
    t_restart();
    tally_and_finish();
  end
endmodule
`default_nettype wire
